// >>> core/ptec_ctrl.sv
// Power and thermal emulation control: registers, power mode, heaters, cut-off, insertion count.
// Assumes a register port already decoded from the serial slave, pins synchronous to clk,
// and an external nonvolatile store that presents its values while the block is in reset.
//
// What this block does
// R1: Eight-bit writable heater power control register.
// R2: Heaters follow new value only in high power.
// R3: Low power mode forces PWM heater off.
// R4: Every power write saved to nonvolatile store.
// R5: Bits 5:0 set PWM heater duty linearly.
// R6: Bit 6 switches first static heater.
// R7: Bit 7 switches second static heater.
// R8: All heaters off at 80 degree cut-off.
// R9: Restore heaters five degrees below cut-off.
// R10: Insertion count increments once per initialization.
// R11: Count low and high bytes readable.
// R12: Reset pin bit reads one; low gives FF.
// R13: Low power pin level readable at bit 0.
// R14: Interrupt pin level readable at bit 0.
// R15: Low power from pin or software override.
// R16: Writing interrupt register sets interrupt pin level.
// R17: Cut-off compares signed 1/256 degree temperature.
// R18: PWM high fraction equals code over 63.
// R19: Count bytes read as consistent 16-bit snapshot.
`timescale 1ns/100ps
`default_nettype none
module ptec_ctrl
	import ptec_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire logic [7:0] reg_page,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic reg_ready,
	output logic reg_rvalid,
	output logic [7:0] reg_rdata,
	// Module pins
	input wire logic module_reset_n_pin,
	input wire logic low_power_pin,
	input wire logic interrupt_n_pin_i,
	output logic interrupt_n_pin_o,
	output logic interrupt_n_pin_oe,
	// Measured temperature
	input wire logic [15:0] temperature,
	// Nonvolatile store
	input wire logic [7:0] nvm_power_value,
	input wire logic [15:0] nvm_count,
	output logic nvm_power_wr,
	output logic [7:0] nvm_power_data,
	output logic nvm_count_wr,
	output logic [15:0] nvm_count_data,
	// Heater drives and status
	output logic pwm_heater,
	output logic static_heater_a,
	output logic static_heater_b,
	output logic low_power_mode,
	output logic over_temp
);

	// True when a register access hits the given address, page checked for the upper half
	function automatic logic ptec_hit(input logic [7:0] page, input logic [7:0] addr,
			input logic [7:0] target);
		ptec_hit = (addr == target) && ((target < ADDR_UPPER_BASE) || (page == PAGE_PIN_STATE));
	endfunction

	ptec_state_t state; // Load after reset, then run
	ptec_state_t next_state;
	logic [7:0] heater_power; // Power control register
	logic [7:0] next_heater_power;
	logic [7:0] applied_power; // Value the heaters currently follow
	logic [7:0] next_applied_power;
	logic [1:0] power_mode; // Override and set bits
	logic [1:0] next_power_mode;
	logic interrupt_level; // Written interrupt pin level
	logic next_interrupt_level;
	logic [15:0] count; // Insertion count
	logic [15:0] next_count;
	logic [7:0] count_high_snap; // High byte caught on a low-byte read
	logic [7:0] next_count_high_snap;
	logic cut_off; // Over-temperature latch
	logic next_cut_off;
	logic next_nvm_power_wr;
	logic next_nvm_count_wr;
	logic [7:0] next_nvm_power_data;
	logic [15:0] next_nvm_count_data;
	logic next_reg_rvalid;
	logic [7:0] next_reg_rdata;
	logic next_static_a;
	logic next_static_b;
	logic low_power_now; // Current power mode decode
	logic heaters_on; // Heaters allowed to dissipate
	logic wr_ok; // Accepted write
	logic rd_ok; // Accepted read

	// Power mode decode and access acceptance
	always_comb begin
		if (power_mode[MODE_OVERRIDE_BIT]) begin
			low_power_now = power_mode[MODE_SET_BIT]; // R15
		end else begin
			low_power_now = low_power_pin; // R15
		end
		heaters_on = !low_power_now && !cut_off;
		reg_ready = (state == ST_RUN);
		wr_ok = reg_wr && reg_ready;
		rd_ok = reg_rd && reg_ready && !reg_wr;
	end

	// Next control state
	always_comb begin
		next_state = state;
		next_heater_power = heater_power;
		next_applied_power = applied_power;
		next_power_mode = power_mode;
		next_interrupt_level = interrupt_level;
		next_count = count;
		next_count_high_snap = count_high_snap;
		next_cut_off = cut_off;
		next_nvm_power_wr = 1'b0;
		next_nvm_count_wr = 1'b0;
		next_nvm_power_data = nvm_power_data;
		next_nvm_count_data = nvm_count_data;
		unique case (state)
			// Restore settings and count one more insertion
			ST_LOAD: begin
				next_heater_power = nvm_power_value; // R4
				next_count = nvm_count + 16'h0001; // R10
				next_nvm_count_data = nvm_count + 16'h0001; // R10
				next_nvm_count_wr = 1'b1; // R10
				next_state = ST_RUN;
			end
			// Serve register writes and catch the count high byte on low-byte reads
			ST_RUN: begin
				if (wr_ok && ptec_hit(reg_page, reg_addr, ADDR_HEATER_POWER_CONTROL)) begin
					next_heater_power = reg_wdata; // R1
					next_nvm_power_data = reg_wdata; // R4
					next_nvm_power_wr = 1'b1; // R4
				end
				if (wr_ok && ptec_hit(reg_page, reg_addr, ADDR_POWER_MODE_CTRL)) begin
					next_power_mode = reg_wdata[1:0];
				end
				if (wr_ok && ptec_hit(reg_page, reg_addr, ADDR_INTERRUPT_PIN_STATE)) begin
					next_interrupt_level = reg_wdata[0]; // R16
				end
				if (rd_ok && ptec_hit(reg_page, reg_addr, ADDR_INSERTION_COUNT_LOW)) begin
					next_count_high_snap = count[15:8]; // R19
				end
			end
		endcase
		// Heaters pick up a new value only in high power
		if (!low_power_now) begin
			next_applied_power = heater_power; // R2
		end
		// Cut-off with hysteresis on the signed temperature
		if ($signed(temperature) >= TEMP_CUTOFF) begin
			next_cut_off = 1'b1; // R8 R17
		end else if ($signed(temperature) <= TEMP_RESTORE) begin
			next_cut_off = 1'b0; // R9
		end
	end

	// Register control state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= ST_LOAD;
			heater_power <= RST_HEATER_POWER;
			applied_power <= RST_HEATER_POWER;
			power_mode <= RST_POWER_MODE;
			interrupt_level <= RST_INTERRUPT_LEVEL;
			count <= RST_COUNT;
			count_high_snap <= RD_ZERO;
			cut_off <= 1'b0;
			nvm_power_wr <= 1'b0;
			nvm_count_wr <= 1'b0;
			nvm_power_data <= RST_HEATER_POWER;
			nvm_count_data <= RST_COUNT;
		end else begin
			state <= next_state;
			heater_power <= next_heater_power;
			applied_power <= next_applied_power;
			power_mode <= next_power_mode;
			interrupt_level <= next_interrupt_level;
			count <= next_count;
			count_high_snap <= next_count_high_snap;
			cut_off <= next_cut_off;
			nvm_power_wr <= next_nvm_power_wr;
			nvm_count_wr <= next_nvm_count_wr;
			nvm_power_data <= next_nvm_power_data;
			nvm_count_data <= next_nvm_count_data;
		end
	end

	// Next read data
	always_comb begin
		next_reg_rvalid = rd_ok;
		next_reg_rdata = reg_rdata;
		if (rd_ok) begin
			next_reg_rdata = RD_ZERO;
			if (!module_reset_n_pin) begin
				next_reg_rdata = RD_ALL_ONES; // R12
			end else if (ptec_hit(reg_page, reg_addr, ADDR_HEATER_POWER_CONTROL)) begin
				next_reg_rdata = heater_power; // R1
			end else if (ptec_hit(reg_page, reg_addr, ADDR_POWER_MODE_CTRL)) begin
				next_reg_rdata = {6'h00, power_mode};
			end else if (ptec_hit(reg_page, reg_addr, ADDR_INSERTION_COUNT_LOW)) begin
				next_reg_rdata = count[7:0]; // R11
			end else if (ptec_hit(reg_page, reg_addr, ADDR_INSERTION_COUNT_HIGH)) begin
				next_reg_rdata = count_high_snap; // R11 R19
			end else if (ptec_hit(reg_page, reg_addr, ADDR_RESET_PIN_STATE)) begin
				next_reg_rdata = 8'h01; // R12
			end else if (ptec_hit(reg_page, reg_addr, ADDR_LOW_POWER_PIN_STATE)) begin
				next_reg_rdata = {7'h00, low_power_pin}; // R13
			end else if (ptec_hit(reg_page, reg_addr, ADDR_INTERRUPT_PIN_STATE)) begin
				next_reg_rdata = {7'h00, interrupt_n_pin_i}; // R14
			end
		end
	end

	// Register read data
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rvalid <= 1'b0;
			reg_rdata <= RD_ZERO;
		end else begin
			reg_rvalid <= next_reg_rvalid;
			reg_rdata <= next_reg_rdata;
		end
	end

	// Next static heater drives
	always_comb begin
		next_static_a = heaters_on && applied_power[PWR_STATIC_A_BIT]; // R6 R8
		next_static_b = heaters_on && applied_power[PWR_STATIC_B_BIT]; // R7 R8
	end

	// Register static heater drives and status
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			static_heater_a <= 1'b0;
			static_heater_b <= 1'b0;
			low_power_mode <= 1'b0;
			over_temp <= 1'b0;
		end else begin
			static_heater_a <= next_static_a;
			static_heater_b <= next_static_b;
			low_power_mode <= low_power_now;
			over_temp <= cut_off;
		end
	end

	// Variable heater, off in low power or after cut-off
	ptec_pwm u_pwm (
		.clk(clk),
		.rst(rst),
		.duty(applied_power[PWR_PWM_MSB:0]), // R5
		.enable(heaters_on), // R3 R8
		.pwm_out(pwm_heater)
	);

	// Open-drain interrupt pin: pulled low only when the level is zero
	assign interrupt_n_pin_o = 1'b0;
	assign interrupt_n_pin_oe = !interrupt_level; // R16

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Register, power and heater checks
	AST_POWER_WRITE_STORED: assert property ( // R1
		wr_ok && ptec_hit(reg_page, reg_addr, ADDR_HEATER_POWER_CONTROL)
		|=> heater_power == $past(reg_wdata))
		else $error("Power control write not stored");
	AST_HOLD_IN_LOW_POWER: assert property ( // R2
		low_power_now |=> applied_power == $past(applied_power))
		else $error("Applied power changed in low power");
	AST_PWM_OFF_LOW_POWER: assert property ( // R3
		low_power_now [*2] |=> !pwm_heater)
		else $error("PWM heater on in low power");
	AST_NVM_SAVE: assert property ( // R4
		wr_ok && ptec_hit(reg_page, reg_addr, ADDR_HEATER_POWER_CONTROL)
		|=> nvm_power_wr && nvm_power_data == $past(reg_wdata))
		else $error("Power write not saved");
	AST_STATIC_A: assert property ( // R6
		!low_power_now && !cut_off && applied_power[PWR_STATIC_A_BIT] |=> static_heater_a)
		else $error("Static heater A not on");
	AST_STATIC_B_CUT: assert property (cut_off |=> !static_heater_b) // R7
		else $error("Static heater B on during cut-off");
	AST_CUTOFF_SET: assert property ( // R8
		$signed(temperature) >= TEMP_CUTOFF |=> cut_off ##1 !static_heater_a)
		else $error("Cut-off not taken");
	AST_PWM_CUT: assert property (cut_off [*2] |=> !pwm_heater) // R8
		else $error("PWM heater on during cut-off");
	AST_HYSTERESIS: assert property ( // R9
		cut_off && $signed(temperature) > TEMP_RESTORE |=> cut_off)
		else $error("Cut-off released above restore point");
	AST_NEG_TEMP_NO_CUT: assert property (!cut_off && temperature[15] |=> !cut_off) // R17
		else $error("Negative temperature took the cut-off");
	AST_COUNT_INCR: assert property ( // R10
		state == ST_LOAD |=> count == $past(nvm_count) + 16'h0001 && nvm_count_wr)
		else $error("Insertion count not incremented");
	AST_READY_AFTER_LOAD: assert property (state == ST_LOAD |=> reg_ready) // R1
		else $error("Register port not ready after load");
	AST_MODE_DECODE: assert property ( // R15
		!power_mode[MODE_OVERRIDE_BIT] |-> low_power_now == low_power_pin)
		else $error("Power mode decode wrong");
	AST_INT_DRIVE: assert property ( // R16
		wr_ok && ptec_hit(reg_page, reg_addr, ADDR_INTERRUPT_PIN_STATE)
		|=> interrupt_n_pin_oe == !$past(reg_wdata[0]))
		else $error("Interrupt pin not driven as written");

	// Read path checks
	AST_RESET_PIN_READ: assert property ( // R12
		rd_ok && !module_reset_n_pin |=> reg_rvalid && reg_rdata == RD_ALL_ONES)
		else $error("Reset pin low read not all ones");
	AST_RESET_PIN_HIGH: assert property ( // R12
		rd_ok && module_reset_n_pin && ptec_hit(reg_page, reg_addr, ADDR_RESET_PIN_STATE)
		|=> reg_rdata == 8'h01)
		else $error("Reset pin high read not one");
	AST_LP_PIN_READ: assert property ( // R13
		rd_ok && module_reset_n_pin && ptec_hit(reg_page, reg_addr, ADDR_LOW_POWER_PIN_STATE)
		|=> reg_rdata == {7'h00, $past(low_power_pin)})
		else $error("Low power pin read wrong");
	AST_INT_PIN_READ: assert property ( // R14
		rd_ok && module_reset_n_pin && ptec_hit(reg_page, reg_addr, ADDR_INTERRUPT_PIN_STATE)
		|=> reg_rdata == {7'h00, $past(interrupt_n_pin_i)})
		else $error("Interrupt pin read wrong");
	AST_COUNT_LOW_READ: assert property ( // R11
		rd_ok && module_reset_n_pin && ptec_hit(reg_page, reg_addr, ADDR_INSERTION_COUNT_LOW)
		|=> reg_rdata == $past(count[7:0]))
		else $error("Count low byte read wrong");
	AST_COUNT_SNAPSHOT: assert property ( // R19
		rd_ok && ptec_hit(reg_page, reg_addr, ADDR_INSERTION_COUNT_LOW)
		|=> count_high_snap == $past(count[15:8]))
		else $error("Count high byte not caught on low read");

	// Scenario covers
	COV_CUTOFF_CYCLE: cover property (cut_off ##[1:1000] !cut_off);
	COV_POWER_WRITE: cover property (nvm_power_wr ##[1:20] static_heater_b);
	COV_COUNT_READ: cover property (rd_ok && ptec_hit(reg_page, reg_addr, ADDR_INSERTION_COUNT_LOW)
		##[1:10] rd_ok && ptec_hit(reg_page, reg_addr, ADDR_INSERTION_COUNT_HIGH));
	COV_LOW_POWER_ENTRY: cover property (!low_power_mode ##1 low_power_mode);
	COV_RESET_PIN_LOW_READ: cover property (rd_ok && !module_reset_n_pin);

endmodule // ptec_ctrl
`default_nettype wire

// >>> core/ptec_pkg.sv
// Package for the power and thermal emulation control block.
// Assumes a 50 MHz system clock and byte-wide register access by page and address.
package ptec_pkg;

	// Clock period in ns
	localparam int CLK_PERIOD_NS = 20;

	// Register byte addresses
	localparam logic [7:0] ADDR_POWER_MODE_CTRL = 8'h5D;
	localparam logic [7:0] ADDR_HEATER_POWER_CONTROL = 8'h62;
	localparam logic [7:0] ADDR_INSERTION_COUNT_LOW = 8'h8D;
	localparam logic [7:0] ADDR_INSERTION_COUNT_HIGH = 8'h8E;
	localparam logic [7:0] ADDR_RESET_PIN_STATE = 8'h91;
	localparam logic [7:0] ADDR_LOW_POWER_PIN_STATE = 8'h92;
	localparam logic [7:0] ADDR_INTERRUPT_PIN_STATE = 8'h93;

	// Upper page that holds the counter and pin state registers
	localparam logic [7:0] PAGE_PIN_STATE = 8'h02;
	// First address of the upper half of the map
	localparam logic [7:0] ADDR_UPPER_BASE = 8'h80;

	// Field positions of the power control register
	localparam int PWR_PWM_MSB = 5;
	localparam int PWR_STATIC_A_BIT = 6;
	localparam int PWR_STATIC_B_BIT = 7;

	// Field positions of the power mode control register
	localparam int MODE_OVERRIDE_BIT = 0;
	localparam int MODE_SET_BIT = 1;

	// Read values
	localparam logic [7:0] RD_ALL_ONES = 8'hFF;
	localparam logic [7:0] RD_ZERO = 8'h00;

	// Reset values
	localparam logic [7:0] RST_HEATER_POWER = 8'h00;
	localparam logic [1:0] RST_POWER_MODE = 2'h0;
	localparam logic RST_INTERRUPT_LEVEL = 1'b1;
	localparam logic [15:0] RST_COUNT = 16'h0000;

	// Temperature thresholds, 1/256 degree steps, signed
	localparam int TEMP_LSB_PER_DEGREE = 256;
	localparam int CUTOFF_DEGREES = 80;
	localparam int HYSTERESIS_DEGREES = 5;
	localparam logic signed [15:0] TEMP_CUTOFF = 16'(CUTOFF_DEGREES * TEMP_LSB_PER_DEGREE);
	localparam logic signed [15:0] TEMP_RESTORE =
		16'((CUTOFF_DEGREES - HYSTERESIS_DEGREES) * TEMP_LSB_PER_DEGREE);

	// PWM timing: one phase step per tick, 63 steps per period
	localparam int PWM_TICK_NS = 1000;
	localparam int PWM_TICK_CYCLES = PWM_TICK_NS / CLK_PERIOD_NS;
	localparam logic [7:0] PWM_TICK_LAST = 8'(PWM_TICK_CYCLES - 1);
	localparam logic [5:0] PWM_PHASE_LAST = 6'h3E;

	// Control state
	typedef enum logic {
		ST_LOAD,
		ST_RUN
	} ptec_state_t;

endpackage

// >>> core/ptec_pwm.sv
// PWM generator for the variable heater.
// Assumes duty is stable enough to be sampled each cycle; period is fixed by package constants.
`timescale 1ns/100ps
`default_nettype none
module ptec_pwm
	import ptec_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control
	input wire logic [5:0] duty,
	input wire logic enable,
	// Drive
	output logic pwm_out
);

	logic [7:0] tick_cnt; // Prescaler
	logic [5:0] phase; // Position in the 63-step period
	logic [7:0] next_tick_cnt;
	logic [5:0] next_phase;
	logic next_pwm_out;

	// Next prescaler, phase and output level
	always_comb begin
		next_tick_cnt = tick_cnt + 8'h01;
		next_phase = phase;
		if (tick_cnt == PWM_TICK_LAST) begin
			next_tick_cnt = 8'h00;
			next_phase = (phase == PWM_PHASE_LAST) ? 6'h00 : phase + 6'h01;
		end
		// High for duty of 63 phases
		next_pwm_out = enable && (phase < duty); // R18
	end

	// Register the generator state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tick_cnt <= 8'h00;
			phase <= 6'h00;
			pwm_out <= 1'b0;
		end else begin
			tick_cnt <= next_tick_cnt;
			phase <= next_phase;
			pwm_out <= next_pwm_out;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_PWM_PHASE_RANGE: assert property (phase <= PWM_PHASE_LAST) // R18
		else $error("PWM phase beyond period");
	AST_PWM_FULL_DUTY: assert property (enable && duty == 6'h3F |=> pwm_out) // R18
		else $error("Full duty did not drive high");

endmodule // ptec_pwm
`default_nettype wire

// >>> verif/ptec_host_model.sv
// Far side of the control block: nonvolatile store and the pulled-up interrupt wire.
// Assumes the store is written only by one-cycle strobes and keeps its contents through rst.
`timescale 1ns/100ps
`default_nettype none
module ptec_host_model
	import ptec_pkg::*;
#(
	parameter logic [7:0] INIT_POWER = 8'hC0,
	parameter logic [15:0] INIT_COUNT = 16'h00FF
) (
	// Clock
	input wire logic clk,
	// Store side
	input wire logic nvm_power_wr,
	input wire logic [7:0] nvm_power_data,
	input wire logic nvm_count_wr,
	input wire logic [15:0] nvm_count_data,
	output logic [7:0] nvm_power_value,
	output logic [15:0] nvm_count,
	// Open-drain interrupt wire
	input wire logic interrupt_n_pin_o,
	input wire logic interrupt_n_pin_oe,
	output logic interrupt_n_pin_i
);
	// Stored values survive the block reset, so no reset here
	initial begin
		nvm_power_value = INIT_POWER;
		nvm_count = INIT_COUNT;
	end

	// Store every power write and every count update
	always @(posedge clk) begin
		if (nvm_power_wr) begin
			nvm_power_value <= nvm_power_data;
		end
		if (nvm_count_wr) begin
			nvm_count <= nvm_count_data;
		end
	end

	// Pull-up wins whenever the block lets go of the wire
	assign interrupt_n_pin_i = interrupt_n_pin_oe ? interrupt_n_pin_o : 1'b1;
endmodule // ptec_host_model
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the power and thermal emulation control block.
// Assumes the host model stands for the store and the pulled-up interrupt wire.
`timescale 1ns/100ps
`default_nettype none
module tb
	import ptec_pkg::*;
;
	// Clock, reset and stimulus
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_page = 8'h00;
	logic [7:0] reg_addr = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic module_reset_n_pin = 1'b1;
	logic low_power_pin = 1'b0;
	logic [15:0] temperature = 16'h0000;
	// Design outputs and model wires
	wire logic reg_ready, reg_rvalid, int_o, int_oe, int_i, nvm_power_wr, nvm_count_wr;
	wire logic pwm_heater, static_heater_a, static_heater_b, low_power_mode, over_temp;
	wire logic [7:0] reg_rdata, nvm_power_value, nvm_power_data;
	wire logic [15:0] nvm_count, nvm_count_data;
	// Bookkeeping
	int n_fail = 0;
	int n_checks = 0;
	int cycles = 0;
	int highs;
	logic [7:0] v;

	// Free-running 50 MHz clock
	always #(CLK_PERIOD_NS / 2) clk = ~clk;

	ptec_ctrl ptec_ctrl_inst (.clk(clk), .rst(rst), .reg_page(reg_page), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_ready(reg_ready),
		.reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata), .module_reset_n_pin(module_reset_n_pin),
		.low_power_pin(low_power_pin), .interrupt_n_pin_i(int_i), .interrupt_n_pin_o(int_o),
		.interrupt_n_pin_oe(int_oe), .temperature(temperature), .nvm_power_value(nvm_power_value),
		.nvm_count(nvm_count), .nvm_power_wr(nvm_power_wr), .nvm_power_data(nvm_power_data),
		.nvm_count_wr(nvm_count_wr), .nvm_count_data(nvm_count_data), .pwm_heater(pwm_heater),
		.static_heater_a(static_heater_a), .static_heater_b(static_heater_b),
		.low_power_mode(low_power_mode), .over_temp(over_temp));

	ptec_host_model ptec_host_model_inst (.clk(clk), .nvm_power_wr(nvm_power_wr),
		.nvm_power_data(nvm_power_data), .nvm_count_wr(nvm_count_wr), .nvm_count_data(nvm_count_data),
		.nvm_power_value(nvm_power_value), .nvm_count(nvm_count), .interrupt_n_pin_o(int_o),
		.interrupt_n_pin_oe(int_oe), .interrupt_n_pin_i(int_i));

	// Expected power mode from pin and software bits
	function automatic logic exp_lp(input logic pin, input logic ov, input logic set);
		return ov ? set : pin;
	endfunction

	// One comparison, counted
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (exp !== got) begin
			$display("ERROR %s expected %h seen %h", name, exp, got);
			n_fail++;
		end
	endtask

	// Verdict and end of run
	task automatic close_out();
		if (n_fail == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// One-cycle write request
	task automatic wr(input logic [7:0] page, input logic [7:0] addr, input logic [7:0] data);
		@(posedge clk);
		reg_page <= page;
		reg_addr <= addr;
		reg_wdata <= data;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// One-cycle read request, answer checked 1 ns after the taking edge
	task automatic rd(input logic [7:0] page, input logic [7:0] addr, input logic [7:0] exp);
		@(posedge clk);
		reg_page <= page;
		reg_addr <= addr;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk("reg_rvalid", 16'h0001, {15'h0000, reg_rvalid});
		chk("reg_rdata", {8'h00, exp}, {8'h00, reg_rdata});
	endtask

	// Let registered heater outputs settle
	task automatic settle();
		repeat (5) @(posedge clk);
		#1;
	endtask

	// Count PWM high cycles over exactly one period
	task automatic measure(output int n);
		n = 0;
		repeat (63 * PWM_TICK_CYCLES) begin
			@(posedge clk);
			#1;
			n += int'(pwm_heater);
		end
	endtask

	// Hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			n_fail++;
			close_out();
		end
	end

	// Main sequence
	initial begin
		void'($urandom(60302));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk("reg_ready", 16'h0001, {15'h0000, reg_ready});
		// Count loaded plus one, carry into the high byte
		chk("nvm_count", 16'h0100, nvm_count);
		rd(PAGE_PIN_STATE, ADDR_INSERTION_COUNT_LOW, 8'h00);
		rd(PAGE_PIN_STATE, ADDR_INSERTION_COUNT_HIGH, 8'h01);
		wr(PAGE_PIN_STATE, ADDR_INSERTION_COUNT_LOW, 8'h5A);
		rd(PAGE_PIN_STATE, ADDR_INSERTION_COUNT_LOW, 8'h00);
		// Stored power applied at start-up
		settle();
		chk("static_heater_a", 16'h0001, {15'h0000, static_heater_a});
		chk("static_heater_b", 16'h0001, {15'h0000, static_heater_b});
		// Random power values, back to back with the read-back
		repeat (4) begin
			v = 8'($urandom);
			wr(8'h00, ADDR_HEATER_POWER_CONTROL, v);
			rd(8'h00, ADDR_HEATER_POWER_CONTROL, v);
			settle();
			chk("nvm_power_value", {8'h00, v}, {8'h00, nvm_power_value});
			chk("static_heater_a", {15'h0000, v[6]}, {15'h0000, static_heater_a});
			chk("static_heater_b", {15'h0000, v[7]}, {15'h0000, static_heater_b});
		end
		// PWM duty at both ends and one random code
		for (int k = 0; k < 3; k++) begin
			v = (k == 0) ? 8'h00 : (k == 1) ? 8'h3F : 8'(1 + $urandom_range(61));
			wr(8'h00, ADDR_HEATER_POWER_CONTROL, v);
			measure(highs);
			measure(highs);
			chk("pwm_high_cycles", 16'(int'(v) * PWM_TICK_CYCLES), 16'(highs));
		end
		// Power mode truth table with every heater requested
		wr(8'h00, ADDR_HEATER_POWER_CONTROL, 8'hFF);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			low_power_pin <= i[0];
			wr(8'h00, ADDR_POWER_MODE_CTRL, {6'h00, i[2], i[1]});
			settle();
			chk("low_power_mode", {15'h0000, exp_lp(i[0], i[1], i[2])}, {15'h0000, low_power_mode});
			chk("pwm_heater", {15'h0000, ~exp_lp(i[0], i[1], i[2])}, {15'h0000, pwm_heater});
			rd(PAGE_PIN_STATE, ADDR_LOW_POWER_PIN_STATE, {7'h00, i[0]});
		end
		// New value written in low power takes effect only in high power
		wr(8'h00, ADDR_POWER_MODE_CTRL, 8'h00);
		wr(8'h00, ADDR_HEATER_POWER_CONTROL, 8'h40);
		settle();
		chk("static_heater_a", 16'h0000, {15'h0000, static_heater_a});
		@(posedge clk);
		low_power_pin <= 1'b0;
		settle();
		chk("static_heater_a", 16'h0001, {15'h0000, static_heater_a});
		chk("static_heater_b", 16'h0000, {15'h0000, static_heater_b});
		chk("nvm_power_value", 16'h0040, {8'h00, nvm_power_value});
		// Cut-off with hysteresis, signed temperatures
		@(posedge clk);
		temperature <= 16'h8000;
		settle();
		chk("over_temp", 16'h0000, {15'h0000, over_temp});
		@(posedge clk);
		temperature <= TEMP_CUTOFF;
		settle();
		chk("static_heater_a", 16'h0000, {15'h0000, static_heater_a});
		@(posedge clk);
		temperature <= 16'h4C00;
		settle();
		chk("over_temp", 16'h0001, {15'h0000, over_temp});
		@(posedge clk);
		temperature <= TEMP_RESTORE;
		settle();
		chk("static_heater_a", 16'h0001, {15'h0000, static_heater_a});
		// Reset pin state, wrong page and unmapped place
		rd(PAGE_PIN_STATE, ADDR_RESET_PIN_STATE, 8'h01);
		rd(8'h01, ADDR_RESET_PIN_STATE, RD_ZERO);
		rd(PAGE_PIN_STATE, 8'h90, RD_ZERO);
		@(posedge clk);
		module_reset_n_pin <= 1'b0;
		rd(PAGE_PIN_STATE, ADDR_RESET_PIN_STATE, RD_ALL_ONES);
		@(posedge clk);
		module_reset_n_pin <= 1'b1;
		// Interrupt wire driven by register writes
		wr(PAGE_PIN_STATE, ADDR_INTERRUPT_PIN_STATE, 8'h00);
		rd(PAGE_PIN_STATE, ADDR_INTERRUPT_PIN_STATE, 8'h00);
		wr(PAGE_PIN_STATE, ADDR_INTERRUPT_PIN_STATE, 8'h01);
		rd(PAGE_PIN_STATE, ADDR_INTERRUPT_PIN_STATE, 8'h01);
		// Mid-run reset: count rises again and the stored power comes back
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk("reg_ready", 16'h0000, {15'h0000, reg_ready});
		chk("static_heater_a", 16'h0000, {15'h0000, static_heater_a});
		@(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk("nvm_count", 16'h0101, nvm_count);
		rd(8'h00, ADDR_HEATER_POWER_CONTROL, 8'h40);
		rd(PAGE_PIN_STATE, ADDR_INSERTION_COUNT_LOW, 8'h01);
		settle();
		chk("static_heater_a", 16'h0001, {15'h0000, static_heater_a});
		close_out();
	end
endmodule // tb
`default_nettype wire
